// [logic/isam_pkg.sv]
// Constants and register map for the sequence input allocation multiplexer.
package isam_pkg;

  localparam int unsigned ISAM_TERM_N  = 7;
  localparam int unsigned ISAM_FUNC_N  = 7;
  localparam int unsigned ISAM_ADDR_W  = 4;
  localparam int unsigned ISAM_DATA_W  = 16;
  localparam int unsigned ISAM_DIGIT_W = 4;
  localparam int unsigned ISAM_SEL_W   = ISAM_FUNC_N * ISAM_DIGIT_W;

  // Register offsets.
  localparam logic [ISAM_ADDR_W-1:0] ISAM_OFS_MAP_FIRST  = 4'h0;
  localparam logic [ISAM_ADDR_W-1:0] ISAM_OFS_MAP_SECOND = 4'h4;
  localparam logic [ISAM_ADDR_W-1:0] ISAM_OFS_STATUS     = 4'h8;

  // Reset values: free mode off, each function on its own terminal.
  localparam logic [ISAM_DATA_W-1:0] ISAM_RST_MAP_FIRST  = 16'h2100;
  localparam logic [ISAM_DATA_W-1:0] ISAM_RST_MAP_SECOND = 16'h6543;

  // Field positions.
  localparam int unsigned ISAM_MODE_LSB = 0;
  localparam int unsigned ISAM_SEL_LSB  = 4;

  // Allocation mode digit values.
  localparam logic [ISAM_DIGIT_W-1:0] ISAM_MODE_LEGACY = 4'h0;
  localparam logic [ISAM_DIGIT_W-1:0] ISAM_MODE_FREE   = 4'h1;

  // Selector codes.
  localparam logic [ISAM_DIGIT_W-1:0] ISAM_CODE_LAST_DIRECT = 4'h6;
  localparam logic [ISAM_DIGIT_W-1:0] ISAM_CODE_FORCE_ON    = 4'h7;
  localparam logic [ISAM_DIGIT_W-1:0] ISAM_CODE_FORCE_OFF   = 4'h8;
  localparam logic [ISAM_DIGIT_W-1:0] ISAM_CODE_FIRST_INV   = 4'h9;

  // Function indices.
  localparam int unsigned ISAM_FN_SERVO_ON  = 0;
  localparam int unsigned ISAM_FN_PCON      = 1;
  localparam int unsigned ISAM_FN_FWD_OT    = 2;
  localparam int unsigned ISAM_FN_REV_OT    = 3;
  localparam int unsigned ISAM_FN_ALARM_RESET_REQUEST   = 4;
  localparam int unsigned ISAM_FN_FWD_TLIM  = 5;
  localparam int unsigned ISAM_FN_REV_TLIM  = 6;

  // Functions whose source is active when low (bit per function index).
  localparam logic [ISAM_FUNC_N-1:0] ISAM_ACTIVE_LOW = 7'h73;
  // Functions that accept no inverted source.
  localparam logic [ISAM_FUNC_N-1:0] ISAM_NO_INVERT  = 7'h40;

endpackage

// [logic/isam_mux.sv]
// Sequence input allocation multiplexer with its mapping registers.
// Notes on behaviour
// - Mode digit zero ignores selectors and uses fixed legacy allocation; zero at reset.
// - Mode digit one takes each function from its own four-bit selector.
// - Codes 0..6 pass terminals 0..6; code 7 forces on, 8 forces off.
// - Codes 9..F feed the inverse of terminals 0..6.
// - Servo-on selector is digit one of first map, default terminal 0, active low.
// - Proportional control is digit two of first map, default terminal 1, active low.
// - Forward overtravel is digit three of first map, default terminal 2, active high.
// - Reverse overtravel is digit zero of second map, default terminal 3, active high.
// - Alarm reset is digit one of second map, default terminal 4, active low.
// - Forward torque limit is digit two of second map, default 5, active low.
// - Reverse torque limit is digit three of second map, default 6, codes 0..8 only.
`timescale 1ns/1ps

module isam_mux
  import isam_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Sequence input terminals
  input  wire logic [ISAM_TERM_N-1:0]  seq_input,
  // Register port
  input  wire logic [ISAM_ADDR_W-1:0]  reg_addr,
  input  wire logic [ISAM_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [ISAM_DATA_W-1:0]  reg_rdata,
  // Function outputs, high while the function is active
  output logic                         servo_on,
  output logic                         proportional_control_request,
  output logic                         forward_overtravel,
  output logic                         reverse_overtravel,
  output logic                         alarm_reset_request,
  output logic                         forward_torque_limit,
  output logic                         reverse_torque_limit
);

  logic [ISAM_TERM_N-1:0]  meta_q;
  logic [ISAM_TERM_N-1:0]  term_q;
  logic [ISAM_DATA_W-1:0]  map_first_q;
  logic [ISAM_DATA_W-1:0]  map_second_q;
  logic [ISAM_DATA_W-1:0]  rdata_q;
  logic [ISAM_FUNC_N-1:0]  func_q;
  logic [ISAM_FUNC_N-1:0]  func_d;
  logic [ISAM_SEL_W-1:0]   sel_all;
  logic [ISAM_SEL_W-1:0]   sel_legacy;
  logic [ISAM_SEL_W-1:0]   sel_used;
  logic                    free_mode;

  // Terminals come from the outside world, so two flops guard against metastability.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      term_q <= '0;
    end else begin
      meta_q <= seq_input;
      term_q <= meta_q;
    end
  end

  // Mapping registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_first_q  <= ISAM_RST_MAP_FIRST;
      map_second_q <= ISAM_RST_MAP_SECOND;
    end else if (reg_wr) begin
      if (reg_addr == ISAM_OFS_MAP_FIRST) begin
        map_first_q <= reg_wdata;
      end
      if (reg_addr == ISAM_OFS_MAP_SECOND) begin
        map_second_q <= reg_wdata;
      end
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ISAM_OFS_MAP_FIRST:  rdata_q <= map_first_q;
        ISAM_OFS_MAP_SECOND: rdata_q <= map_second_q;
        ISAM_OFS_STATUS:     rdata_q <= {{(ISAM_DATA_W-ISAM_FUNC_N){1'b0}}, func_q};
        default:             rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // Function selectors in function-index order, digit 1 of the first map upward.
  assign sel_all = {map_second_q, map_first_q[ISAM_DATA_W-1:ISAM_SEL_LSB]};
  // Any mode value other than one keeps the fixed allocation, the safe reading.
  assign free_mode = map_first_q[ISAM_MODE_LSB +: ISAM_DIGIT_W] == ISAM_MODE_FREE;

  genvar gi;
  generate
    for (gi = 0; gi < ISAM_FUNC_N; gi++) begin : g_fn
      // Legacy allocation wires each function straight to its own terminal.
      assign sel_legacy[gi*ISAM_DIGIT_W +: ISAM_DIGIT_W] = ISAM_DIGIT_W'(gi);
      assign sel_used[gi*ISAM_DIGIT_W +: ISAM_DIGIT_W] = free_mode ?
        sel_all[gi*ISAM_DIGIT_W +: ISAM_DIGIT_W] :
        sel_legacy[gi*ISAM_DIGIT_W +: ISAM_DIGIT_W];

      logic [ISAM_DIGIT_W-1:0] code;
      logic [ISAM_DIGIT_W-1:0] inv_idx;
      assign code    = sel_used[gi*ISAM_DIGIT_W +: ISAM_DIGIT_W];
      assign inv_idx = code - ISAM_CODE_FIRST_INV;

      always_comb begin
        if (code <= ISAM_CODE_LAST_DIRECT) begin
          func_d[gi] = term_q[code[2:0]] ^ ISAM_ACTIVE_LOW[gi];
        end else if (code == ISAM_CODE_FORCE_ON) begin
          func_d[gi] = 1'b1;
        end else if (code == ISAM_CODE_FORCE_OFF) begin
          func_d[gi] = 1'b0;
        end else if (ISAM_NO_INVERT[gi]) begin
          // Inverted codes are illegal here; treat them as forced off.
          func_d[gi] = 1'b0;
        end else begin
          func_d[gi] = ~term_q[inv_idx[2:0]] ^ ISAM_ACTIVE_LOW[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= '0;
    end else begin
      func_q <= func_d;
    end
  end

  assign reg_rdata                    = rdata_q;
  assign servo_on                     = func_q[ISAM_FN_SERVO_ON];
  assign proportional_control_request = func_q[ISAM_FN_PCON];
  assign forward_overtravel           = func_q[ISAM_FN_FWD_OT];
  assign reverse_overtravel           = func_q[ISAM_FN_REV_OT];
  assign alarm_reset_request          = func_q[ISAM_FN_ALARM_RESET_REQUEST];
  assign forward_torque_limit         = func_q[ISAM_FN_FWD_TLIM];
  assign reverse_torque_limit         = func_q[ISAM_FN_REV_TLIM];

  // Checks. Outputs lag the selectors by one edge, so each property also needs reset
  // to have been off at the edge it looks back to; otherwise the reset value would fire it.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Legacy allocation: function i follows terminal i with its own polarity.
  property p_legacy_servo;
    $past(rst_n) && !$past(free_mode) |-> servo_on == !$past(term_q[0]);
  endproperty
  a_legacy_servo: assert property (p_legacy_servo)
    else $error("legacy servo-on not taken from terminal 0");

  property p_legacy_pcon;
    $past(rst_n) && !$past(free_mode) |-> proportional_control_request == !$past(term_q[1]);
  endproperty
  a_legacy_pcon: assert property (p_legacy_pcon)
    else $error("legacy proportional control not taken from terminal 1");

  property p_legacy_fwd_ot;
    $past(rst_n) && !$past(free_mode) |-> forward_overtravel == $past(term_q[2]);
  endproperty
  a_legacy_fwd_ot: assert property (p_legacy_fwd_ot)
    else $error("legacy forward overtravel not taken from terminal 2");

  property p_legacy_rev_ot;
    $past(rst_n) && !$past(free_mode) |-> reverse_overtravel == $past(term_q[3]);
  endproperty
  a_legacy_rev_ot: assert property (p_legacy_rev_ot)
    else $error("legacy reverse overtravel not taken from terminal 3");

  property p_legacy_alm;
    $past(rst_n) && !$past(free_mode) |-> alarm_reset_request == !$past(term_q[4]);
  endproperty
  a_legacy_alm: assert property (p_legacy_alm)
    else $error("legacy alarm reset not taken from terminal 4");

  property p_legacy_fwd_tlim;
    $past(rst_n) && !$past(free_mode) |-> forward_torque_limit == !$past(term_q[5]);
  endproperty
  a_legacy_fwd_tlim: assert property (p_legacy_fwd_tlim)
    else $error("legacy forward torque limit not taken from terminal 5");

  property p_legacy_rev_tlim;
    $past(rst_n) && !$past(free_mode) |-> reverse_torque_limit == !$past(term_q[6]);
  endproperty
  a_legacy_rev_tlim: assert property (p_legacy_rev_tlim)
    else $error("legacy reverse torque limit not taken from terminal 6");

  // Free allocation: every code class is watched on at least one function.
  property p_free_force_on;
    $past(rst_n) && $past(free_mode) && $past(sel_all[3:0]) == 4'h7 |-> servo_on;
  endproperty
  a_free_force_on: assert property (p_free_force_on)
    else $error("code 7 did not force servo-on");

  property p_force_on_fwd_tlim;
    $past(rst_n) && $past(free_mode) && $past(sel_all[23:20]) == 4'h7 |-> forward_torque_limit;
  endproperty
  a_force_on_fwd_tlim: assert property (p_force_on_fwd_tlim)
    else $error("code 7 did not force forward torque limit");

  property p_force_on_rev_ot;
    $past(rst_n) && $past(free_mode) && $past(sel_all[15:12]) == 4'h7 |-> reverse_overtravel;
  endproperty
  a_force_on_rev_ot: assert property (p_force_on_rev_ot)
    else $error("code 7 did not force reverse overtravel");

  property p_force_off;
    $past(rst_n) && $past(free_mode) && $past(sel_all[7:4]) == 4'h8 |->
      !proportional_control_request;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("code 8 did not force off");

  property p_force_off_rev_tlim;
    $past(rst_n) && $past(free_mode) && $past(sel_all[27:24]) == 4'h8 |->
      !reverse_torque_limit;
  endproperty
  a_force_off_rev_tlim: assert property (p_force_off_rev_tlim)
    else $error("code 8 did not force reverse torque limit off");

  property p_direct_high;
    $past(rst_n) && $past(free_mode) && $past(sel_all[11:8]) == 4'h5 |->
      forward_overtravel == $past(term_q[5]);
  endproperty
  a_direct_high: assert property (p_direct_high)
    else $error("forward overtravel not direct from terminal 5");

  property p_direct_low;
    $past(rst_n) && $past(free_mode) && $past(sel_all[3:0]) == 4'h6 |->
      servo_on == !$past(term_q[6]);
  endproperty
  a_direct_low: assert property (p_direct_low)
    else $error("servo-on not active low on terminal 6");

  property p_fwd_tlim_direct;
    $past(rst_n) && $past(free_mode) && $past(sel_all[23:20]) == 4'h0 |->
      forward_torque_limit == !$past(term_q[0]);
  endproperty
  a_fwd_tlim_direct: assert property (p_fwd_tlim_direct)
    else $error("forward torque limit not active low on terminal 0");

  property p_alm_direct;
    $past(rst_n) && $past(free_mode) && $past(sel_all[19:16]) == 4'h4 |->
      alarm_reset_request == !$past(term_q[4]);
  endproperty
  a_alm_direct: assert property (p_alm_direct)
    else $error("alarm reset not active low on terminal 4");

  property p_invert;
    $past(rst_n) && $past(free_mode) && $past(sel_all[19:16]) == 4'hb |->
      alarm_reset_request == $past(term_q[2]);
  endproperty
  a_invert: assert property (p_invert)
    else $error("code b did not invert terminal 2");

  property p_pcon_invert;
    $past(rst_n) && $past(free_mode) && $past(sel_all[7:4]) == 4'hf |->
      proportional_control_request == $past(term_q[6]);
  endproperty
  a_pcon_invert: assert property (p_pcon_invert)
    else $error("code f did not invert terminal 6");

  property p_rev_ot_invert;
    $past(rst_n) && $past(free_mode) && $past(sel_all[15:12]) == 4'h9 |->
      reverse_overtravel == !$past(term_q[0]);
  endproperty
  a_rev_ot_invert: assert property (p_rev_ot_invert)
    else $error("code 9 did not invert terminal 0");

  property p_no_invert;
    $past(rst_n) && $past(free_mode) && $past(sel_all[27:24]) > 4'h8 |->
      !reverse_torque_limit;
  endproperty
  a_no_invert: assert property (p_no_invert)
    else $error("reverse torque limit accepted an inverted code");

  // Selector digit placement in the two mapping words.
  property p_first_digit;
    reg_wr && reg_addr == ISAM_OFS_MAP_FIRST |=> sel_all[3:0] == $past(reg_wdata[7:4]);
  endproperty
  a_first_digit: assert property (p_first_digit)
    else $error("servo-on selector not in digit one");

  property p_first_pcon_digit;
    reg_wr && reg_addr == ISAM_OFS_MAP_FIRST |=> sel_all[7:4] == $past(reg_wdata[11:8]);
  endproperty
  a_first_pcon_digit: assert property (p_first_pcon_digit)
    else $error("proportional control selector not in digit two");

  property p_second_digit;
    reg_wr && reg_addr == ISAM_OFS_MAP_SECOND |=> sel_all[15:12] == $past(reg_wdata[3:0]);
  endproperty
  a_second_digit: assert property (p_second_digit)
    else $error("reverse overtravel selector not in digit zero");

  property p_second_high_digit;
    reg_wr && reg_addr == ISAM_OFS_MAP_SECOND |=> sel_all[27:24] == $past(reg_wdata[15:12]);
  endproperty
  a_second_high_digit: assert property (p_second_high_digit)
    else $error("reverse torque limit selector not in digit three");

  // Pin to output: two synchroniser stages and the output flop, all out of reset.
  property p_pin_latency;
    $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) &&
      !$past(free_mode) && !$past(free_mode, 2) && !$past(free_mode, 3) |->
      reverse_overtravel == $past(seq_input[3], 3);
  endproperty
  a_pin_latency: assert property (p_pin_latency)
    else $error("terminal did not reach output in three edges");

  c_free_mode: cover property (reg_wr && reg_addr == ISAM_OFS_MAP_FIRST && reg_wdata[3:0] == 4'h1);
  c_invert:    cover property (free_mode && sel_all[3:0] == 4'h9 ##1 servo_on);
  c_status:    cover property (reg_rd && reg_addr == ISAM_OFS_STATUS ##1 reg_rdata != '0);
  c_legacy:    cover property (map_first_q[ISAM_MODE_LSB +: ISAM_DIGIT_W] == ISAM_MODE_LEGACY
                               && !servo_on);

endmodule

// [dv/isam_host_model.sv]
// Host controller model that drives the sequence input terminals.
`timescale 1ns/1ps
module isam_host_model
  import isam_pkg::*;
(
  // Clock
  input  wire logic                   clk,
  // Requested and driven terminal levels
  input  wire logic [ISAM_TERM_N-1:0] level_req,
  output logic      [ISAM_TERM_N-1:0] seq_input
);
  // Pins move just after an edge, so the block sees no change at its own sampling instant.
  always_ff @(posedge clk) begin
    seq_input <= level_req;
  end
endmodule

// [dv/tb_isam_mux.sv]
// Self-checking testbench for the sequence input allocation multiplexer.
`timescale 1ns/1ps
module tb_isam_mux
  import isam_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [6:0]  term_req = 7'h00;
  wire  [6:0]  seq_input;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [15:0] reg_rdata;
  wire  [6:0]  fn;
  logic [15:0] rd_val;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  isam_host_model u_host (.clk(clk), .level_req(term_req), .seq_input(seq_input));
  isam_mux u_dut (.clk(clk), .rst_n(rst_n), .seq_input(seq_input), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .servo_on(fn[0]), .proportional_control_request(fn[1]), .forward_overtravel(fn[2]),
    .reverse_overtravel(fn[3]), .alarm_reset_request(fn[4]), .forward_torque_limit(fn[5]),
    .reverse_torque_limit(fn[6]));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  function automatic logic [6:0] expv(input logic [15:0] m1, m2, input logic [6:0] t);
    logic [27:0] sel;
    logic [3:0]  c;
    logic        s;
    logic [6:0]  e;
    sel = {m2, m1[15:4]};
    for (int f = 0; f < 7; f++) begin
      c = (m1[3:0] == 4'h1) ? sel[4*f+:4] : 4'(f);
      if (c <= 4'h6) s = t[c];
      else if (c >= 4'h9) s = ISAM_NO_INVERT[f] ? ISAM_ACTIVE_LOW[f] : ~t[c-4'h9];
      else s = (c == 4'h7) ^ ISAM_ACTIVE_LOW[f];
      e[f] = ISAM_ACTIVE_LOW[f] ? ~s : s;
    end
    return e;
  endfunction

  // Waits out the two synchroniser stages and the output flop with margin.
  task automatic apply(input logic [6:0] t, input logic [15:0] m1, m2);
    @(posedge clk);
    term_req <= t;
    repeat (6) @(posedge clk);
    #1 check({9'h000, fn}, {9'h000, expv(m1, m2, t)}, "function outputs");
  endtask

  task automatic t_reset();
    rd(ISAM_OFS_MAP_FIRST);
    check(rd_val, 16'h2100, "first map reset");
    rd(ISAM_OFS_MAP_SECOND);
    check(rd_val, 16'h6543, "second map reset");
    apply(7'h55, 16'h2100, 16'h6543);
    apply(7'h2a, 16'h2100, 16'h6543);
    $display("test reset done");
  endtask

  task automatic t_legacy();
    wr(ISAM_OFS_MAP_FIRST, 16'h8170);
    wr(ISAM_OFS_MAP_SECOND, 16'h6548);
    apply(7'h5a, 16'h8170, 16'h6548);
    apply(7'h25, 16'h8170, 16'h6548);
    rd(ISAM_OFS_MAP_FIRST);
    check(rd_val, 16'h8170, "first map readback");
    $display("test legacy done");
  endtask

  // Each function gets a different code per pass, so digit placement errors show.
  task automatic t_codes();
    logic [15:0] m1;
    logic [15:0] m2;
    for (int c = 0; c < 16; c++) begin
      m1 = {4'(c + 2), 4'(c + 1), 4'(c), 4'h1};
      m2 = {4'(c + 6), 4'(c + 5), 4'(c + 4), 4'(c + 3)};
      wr(ISAM_OFS_MAP_FIRST, m1);
      wr(ISAM_OFS_MAP_SECOND, m2);
      apply(7'h35, m1, m2);
      apply(7'h4a, m1, m2);
    end
    rd(ISAM_OFS_STATUS);
    check(rd_val, {9'h000, expv(m1, m2, 7'h4a)}, "status");
    rd(4'hc);
    check(rd_val, 16'h0000, "unmapped read");
    $display("test codes done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_legacy();
    t_codes();
    print_verdict();
  end
endmodule
